//--- hw/alarm_channel_compare.sv
// one channel comparator with falling-side hysteresis
`default_nettype none
module alarm_channel_compare #(
   parameter int TEMP_W = 8
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [TEMP_W-1:0] i_reading,
   input wire logic [TEMP_W-1:0] i_limit,
   input wire logic [4:0] i_hyst,
   output logic o_status
);
   // the hysteresis field is five bits wide, so narrower readings cannot be served
   if (TEMP_W < 5) begin : g_width_check
      $error("TEMP_W too small");
   end
   // one extra bit flags the borrow when hysteresis exceeds the limit, which then blocks clearing
   logic [TEMP_W:0] clear_level;
   assign clear_level = {1'b0, i_limit} - {{(TEMP_W-4){1'b0}}, i_hyst};
   // ----------------------------------------
   // status flag
   // ----------------------------------------
   // sets at or above limit, clears only below limit minus hysteresis
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_status <= 1'b0;
      end else if ({1'b0, i_reading} >= {1'b0, i_limit}) begin
         o_status <= 1'b1;
      end else if (!clear_level[TEMP_W] && ({1'b0, i_reading} < clear_level)) begin
         o_status <= 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- hw/temp_alarm_map.svh
// register offsets, reset values and field positions of the alarm threshold bank
`ifndef TEMP_ALARM_MAP_SVH
`define TEMP_ALARM_MAP_SVH
`define ADDR_ALARM3_CHANNEL_MASK 8'h0E
`define ADDR_LOCAL_CRITICAL_LIMIT 8'h40
`define ADDR_REMOTE1_ALARM1_LIMIT 8'h41
`define ADDR_REMOTE2_ALARM1_LIMIT 8'h42
`define ADDR_REMOTE1_ALARM23_LIMIT 8'h49
`define ADDR_REMOTE2_ALARM23_LIMIT 8'h4A
`define ADDR_SHARED_ALARM_HYSTERESIS 8'h5A
`define ADDR_MAKER_IDENTITY 8'hFE
`define ADDR_SILICON_REVISION 8'hFF
`define RST_ALARM3_CHANNEL_MASK 3'h7
`define RST_LOCAL_CRITICAL_LIMIT 7'h55
`define RST_REMOTE_ALARM1_LIMIT 8'h6E
`define RST_REMOTE_ALARM23_LIMIT 8'h55
`define RST_SHARED_ALARM_HYSTERESIS 5'h0A
`define MASK_W 3
`define LOCAL_LIMIT_W 7
`define HYST_W 5
`define BIT_LOCAL_BLOCK 0
`define BIT_REMOTE1_BLOCK 1
`define BIT_REMOTE2_BLOCK 2
`endif

//--- hw/temp_alarm_pkg.sv
// types shared by the alarm threshold bank
`default_nettype none
package temp_alarm_pkg;
   typedef logic [7:0] temp_t;
   typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

//--- hw/temp_alarm_threshold_regs.sv
// alarm threshold register bank, compare and active-low alarm outputs
`include "temp_alarm_map.svh"
`default_nettype none
module temp_alarm_threshold_regs #(
   parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
   parameter logic [7:0] SILICON_REVISION = 8'h10 // arbitrary value
) (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   input wire logic [7:0] i_local_temp,
   input wire logic [7:0] i_remote1_temp,
   input wire logic [7:0] i_remote2_temp,
   input wire logic [2:0] i_alarm1_mask,
   input wire logic [2:0] i_alarm2_mask,
   output logic [2:0] o_alarm1_status,
   output logic [2:0] o_alarm23_status,
   output logic o_alarm_out_first_n,
   output logic o_alarm_out_second_n,
   output logic o_alarm_out_third_n
);
   logic [`MASK_W-1:0] alarm3_channel_mask;
   logic [`LOCAL_LIMIT_W-1:0] local_critical_limit;
   temp_alarm_pkg::temp_t remote1_alarm1_limit;
   temp_alarm_pkg::temp_t remote2_alarm1_limit;
   temp_alarm_pkg::temp_t remote1_alarm23_limit;
   temp_alarm_pkg::temp_t remote2_alarm23_limit;
   logic [`HYST_W-1:0] shared_alarm_hysteresis;
   temp_alarm_pkg::reg_byte_t next_rdata;
   logic [2:0] next_alarm_out;

   // ----------------------------------------
   // writable registers
   // ----------------------------------------
   // one enable per register; identity and unmapped addresses decode to none,
   // so a write there is dropped without touching any state
   logic wr_mask;
   logic wr_local;
   logic wr_r1_a1;
   logic wr_r2_a1;
   logic wr_r1_a23;
   logic wr_r2_a23;
   logic wr_hyst;
   assign wr_mask = i_reg_wr && (i_reg_addr == `ADDR_ALARM3_CHANNEL_MASK);
   assign wr_local = i_reg_wr && (i_reg_addr == `ADDR_LOCAL_CRITICAL_LIMIT);
   assign wr_r1_a1 = i_reg_wr && (i_reg_addr == `ADDR_REMOTE1_ALARM1_LIMIT);
   assign wr_r2_a1 = i_reg_wr && (i_reg_addr == `ADDR_REMOTE2_ALARM1_LIMIT);
   assign wr_r1_a23 = i_reg_wr && (i_reg_addr == `ADDR_REMOTE1_ALARM23_LIMIT);
   assign wr_r2_a23 = i_reg_wr && (i_reg_addr == `ADDR_REMOTE2_ALARM23_LIMIT);
   assign wr_hyst = i_reg_wr && (i_reg_addr == `ADDR_SHARED_ALARM_HYSTERESIS);

   // third alarm mask; only the block bits are stored, so reserved bits cannot change
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         alarm3_channel_mask <= `RST_ALARM3_CHANNEL_MASK;
      end else if (wr_mask) begin
         alarm3_channel_mask <= i_reg_wdata[`MASK_W-1:0];
      end
   end

   // local limit; bit 7 is not stored, which caps the limit at 127
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         local_critical_limit <= `RST_LOCAL_CRITICAL_LIMIT;
      end else if (wr_local) begin
         local_critical_limit <= i_reg_wdata[`LOCAL_LIMIT_W-1:0];
      end
   end

   // remote 1 limit for the first alarm only
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         remote1_alarm1_limit <= `RST_REMOTE_ALARM1_LIMIT;
      end else if (wr_r1_a1) begin
         remote1_alarm1_limit <= i_reg_wdata;
      end
   end

   // remote 2 limit for the first alarm only
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         remote2_alarm1_limit <= `RST_REMOTE_ALARM1_LIMIT;
      end else if (wr_r2_a1) begin
         remote2_alarm1_limit <= i_reg_wdata;
      end
   end

   // remote 1 limit shared by second and third alarms
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         remote1_alarm23_limit <= `RST_REMOTE_ALARM23_LIMIT;
      end else if (wr_r1_a23) begin
         remote1_alarm23_limit <= i_reg_wdata;
      end
   end

   // remote 2 limit shared by second and third alarms
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         remote2_alarm23_limit <= `RST_REMOTE_ALARM23_LIMIT;
      end else if (wr_r2_a23) begin
         remote2_alarm23_limit <= i_reg_wdata;
      end
   end

   // common hysteresis; a new value takes effect on the next compare edge
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shared_alarm_hysteresis <= `RST_SHARED_ALARM_HYSTERESIS;
      end else if (wr_hyst) begin
         shared_alarm_hysteresis <= i_reg_wdata[`HYST_W-1:0];
      end
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   // unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      unique case (i_reg_addr)
         `ADDR_ALARM3_CHANNEL_MASK: next_rdata = {5'h00, alarm3_channel_mask};
         `ADDR_LOCAL_CRITICAL_LIMIT: next_rdata = {1'b0, local_critical_limit};
         `ADDR_REMOTE1_ALARM1_LIMIT: next_rdata = remote1_alarm1_limit;
         `ADDR_REMOTE2_ALARM1_LIMIT: next_rdata = remote2_alarm1_limit;
         `ADDR_REMOTE1_ALARM23_LIMIT: next_rdata = remote1_alarm23_limit;
         `ADDR_REMOTE2_ALARM23_LIMIT: next_rdata = remote2_alarm23_limit;
         `ADDR_SHARED_ALARM_HYSTERESIS: next_rdata = {3'h0, shared_alarm_hysteresis};
         `ADDR_MAKER_IDENTITY: next_rdata = MAKER_ID;
         `ADDR_SILICON_REVISION: next_rdata = SILICON_REVISION;
         default: next_rdata = 8'h00;
      endcase
   end

   // registered read data, one cycle after the address
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_reg_rdata <= 8'h00;
      end else begin
         o_reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // channel comparators
   // ----------------------------------------
   // local status is shared by all outputs since one local limit serves them
   alarm_channel_compare #(.TEMP_W(8)) u_local (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_reading(i_local_temp),
      .i_limit({1'b0, local_critical_limit}),
      .i_hyst(shared_alarm_hysteresis),
      .o_status(o_alarm1_status[`BIT_LOCAL_BLOCK])
   );
   assign o_alarm23_status[`BIT_LOCAL_BLOCK] = o_alarm1_status[`BIT_LOCAL_BLOCK];

   alarm_channel_compare #(.TEMP_W(8)) u_r1_a1 (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_reading(i_remote1_temp),
      .i_limit(remote1_alarm1_limit),
      .i_hyst(shared_alarm_hysteresis),
      .o_status(o_alarm1_status[`BIT_REMOTE1_BLOCK])
   );
   alarm_channel_compare #(.TEMP_W(8)) u_r2_a1 (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_reading(i_remote2_temp),
      .i_limit(remote2_alarm1_limit),
      .i_hyst(shared_alarm_hysteresis),
      .o_status(o_alarm1_status[`BIT_REMOTE2_BLOCK])
   );
   alarm_channel_compare #(.TEMP_W(8)) u_r1_a23 (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_reading(i_remote1_temp),
      .i_limit(remote1_alarm23_limit),
      .i_hyst(shared_alarm_hysteresis),
      .o_status(o_alarm23_status[`BIT_REMOTE1_BLOCK])
   );
   alarm_channel_compare #(.TEMP_W(8)) u_r2_a23 (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_reading(i_remote2_temp),
      .i_limit(remote2_alarm23_limit),
      .i_hyst(shared_alarm_hysteresis),
      .o_status(o_alarm23_status[`BIT_REMOTE2_BLOCK])
   );

   // ----------------------------------------
   // alarm outputs
   // ----------------------------------------
   // a set mask bit blocks the channel; outputs active low
   assign next_alarm_out[0] = |(o_alarm1_status & ~i_alarm1_mask);
   assign next_alarm_out[1] = |(o_alarm23_status & ~i_alarm2_mask);
   assign next_alarm_out[2] = |(o_alarm23_status & ~alarm3_channel_mask);

   // pins registered to keep them glitch free
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_alarm_out_first_n <= 1'b1;
         o_alarm_out_second_n <= 1'b1;
         o_alarm_out_third_n <= 1'b1;
      end else begin
         o_alarm_out_first_n <= ~next_alarm_out[0];
         o_alarm_out_second_n <= ~next_alarm_out[1];
         o_alarm_out_third_n <= ~next_alarm_out[2];
      end
   end
endmodule
`default_nettype wire

//--- testbench/host_model.sv
// host model driving the register command bus
`default_nettype none
module host_model (
   input wire logic i_core_clk,
   input wire logic [7:0] i_rdata,
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idles with no strobe until the first task call, so nothing unknown reaches it
   initial begin
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_wdata = 8'h00;
   end
   // one-cycle strobe; released data shows its inverse, not a stale copy
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      o_addr = a;
      o_wr = 1'b1;
      o_wdata = d;
      @(negedge i_core_clk);
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
   // read data is registered, so it lands one edge after the address
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_core_clk);
      o_addr = a;
      @(negedge i_core_clk);
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the alarm threshold bank
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER = 8'h3C; // arbitrary value
   localparam logic [7:0] REV = 8'h21; // arbitrary value
   typedef struct {logic [7:0] a; logic [7:0] rst; logic [7:0] w; logic [7:0] exp;} row_s;
   // address, reset value, written byte, expected read-back
   row_s rows [10] = '{'{8'h0E, 8'h07, 8'hFA, 8'h02}, '{8'h40, 8'h55, 8'hB0, 8'h30},
      '{8'h41, 8'h6E, 8'hA5, 8'hA5}, '{8'h42, 8'h6E, 8'h5A, 8'h5A}, '{8'h49, 8'h55, 8'h60, 8'h60},
      '{8'h4A, 8'h55, 8'h3C, 8'h3C}, '{8'h5A, 8'h0A, 8'hEA, 8'h0A}, '{8'hFE, MAKER, 8'h00, MAKER},
      '{8'hFF, REV, 8'h00, REV}, '{8'h33, 8'h00, 8'h77, 8'h00}};
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic [7:0] addr, wdata, rdata, got;
   logic [7:0] loc = 8'h00, rm1 = 8'h00, rm2 = 8'h00;
   logic [2:0] m1 = 3'h0, m2 = 3'h0, s1, s23;
   logic wr, p1, p2, p3;
   int bad_count = 0;
   int total_checks = 0;
   host_model host (.i_core_clk, .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_wdata(wdata));
   temp_alarm_threshold_regs #(.MAKER_ID(MAKER), .SILICON_REVISION(REV)) dut (.i_core_clk, .i_nrst,
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
      .i_local_temp(loc), .i_remote1_temp(rm1), .i_remote2_temp(rm2), .i_alarm1_mask(m1),
      .i_alarm2_mask(m2), .o_alarm1_status(s1), .o_alarm23_status(s23),
      .o_alarm_out_first_n(p1), .o_alarm_out_second_n(p2), .o_alarm_out_third_n(p3));
   initial begin
      forever #10 i_core_clk = ~i_core_clk;
   end
   task automatic check(input logic [11:0] g, input logic [11:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // readings land at a falling edge; status needs one rising edge and pins need two
   task automatic step(input logic [7:0] l, input logic [7:0] r1, input logic [7:0] r2,
      input logic [11:0] e);
      @(negedge i_core_clk);
      loc = l;
      rm1 = r1;
      rm2 = r2;
      repeat (3) @(negedge i_core_clk);
      check({3'h0, s1, s23, p1, p2, p3}, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // generous bound: the sequence needs about a hundred cycles
   initial begin
      #(20 * 3000);
      bad_count++;
      tally_and_finish;
   end
   initial begin
      repeat (12) @(negedge i_core_clk);
      i_nrst = 1'b1;
      foreach (rows[i]) begin
         host.read_reg(rows[i].a, got);
         check({4'h0, got}, {4'h0, rows[i].rst});
         host.write_reg(rows[i].a, rows[i].w);
         host.read_reg(rows[i].a, got);
         check({4'h0, got}, {4'h0, rows[i].exp});
      end
      $display("register table done");
      step(8'h00, 8'h60, 8'h00, 12'h015);
      step(8'h00, 8'h56, 8'h00, 12'h015);
      step(8'h00, 8'h55, 8'h00, 12'h007);
      step(8'h30, 8'h00, 8'h00, 12'h048);
      step(8'h00, 8'h00, 8'h70, 12'h120);
      m1 = 3'h4;
      m2 = 3'h4;
      step(8'h00, 8'h00, 8'h70, 12'h126);
      $display("alarm path done");
      // mid-run reset clears status and releases pins while the reading stays hot
      i_nrst = 1'b0;
      @(negedge i_core_clk);
      check({3'h0, s1, s23, p1, p2, p3}, 12'h007);
      i_nrst = 1'b1;
      step(8'h00, 8'h00, 8'h70, 12'h127);
      $display("reset test done");
      tally_and_finish;
   end
endmodule
`default_nettype wire

//--- testbench/temp_alarm_properties.sv
// concurrent checks on the alarm threshold bank ports
`default_nettype none
module temp_alarm_checker (
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [2:0] i_alarm1_mask,
   input wire logic [2:0] i_alarm2_mask,
   input wire logic [2:0] o_alarm1_status,
   input wire logic [2:0] o_alarm23_status,
   input wire logic o_alarm_out_first_n,
   input wire logic o_alarm_out_second_n,
   input wire logic o_alarm_out_third_n
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // a write, then one idle cycle on the same address
   sequence wr_rd(logic [7:0] a);
      i_reg_wr && i_reg_addr == a ##1 !i_reg_wr && i_reg_addr == a;
   endsequence
   // pins follow the previous cycle's unmasked status
   first_pin_a: assert property (o_alarm_out_first_n ==
      !(|($past(o_alarm1_status) & ~$past(i_alarm1_mask)))) else $error("first pin wrong");
   second_pin_a: assert property (o_alarm_out_second_n ==
      !(|($past(o_alarm23_status) & ~$past(i_alarm2_mask)))) else $error("second pin wrong");
   // the third pin may only fall after some shared-limit status was set
   third_pin_a: assert property ($past(o_alarm23_status) == 3'h0 |->
      o_alarm_out_third_n) else $error("third pin without status");
   local_shared_a: assert property (o_alarm1_status[0] == o_alarm23_status[0])
      else $error("local status split");
   // read-back after write keeps only the writable bits
   mask_write_a: assert property (wr_rd(8'h0E) |=>
      o_reg_rdata == {5'h00, $past(i_reg_wdata[2:0], 2)}) else $error("mask readback");
   local_write_a: assert property (wr_rd(8'h40) |=>
      o_reg_rdata == {1'b0, $past(i_reg_wdata[6:0], 2)}) else $error("local limit readback");
   remote_write_a: assert property (wr_rd(8'h41) |=>
      o_reg_rdata == $past(i_reg_wdata, 2)) else $error("remote limit readback");
   remote23_write_a: assert property (wr_rd(8'h49) |=>
      o_reg_rdata == $past(i_reg_wdata, 2)) else $error("shared limit readback");
   hyst_write_a: assert property (wr_rd(8'h5A) |=>
      o_reg_rdata == {3'h0, $past(i_reg_wdata[4:0], 2)}) else $error("hysteresis readback");
endmodule
bind temp_alarm_threshold_regs temp_alarm_checker chk (.i_core_clk, .i_nrst, .i_reg_addr,
   .i_reg_wr, .i_reg_wdata, .o_reg_rdata, .i_alarm1_mask, .i_alarm2_mask, .o_alarm1_status,
   .o_alarm23_status, .o_alarm_out_first_n, .o_alarm_out_second_n, .o_alarm_out_third_n);
`default_nettype wire
